// ===== core/led_bank_routing_pkg.sv
// constants, types and the power-on register map of the backlight configuration bank
// assumes a two-wire serial bus master that writes the register address before any data
package led_bank_routing_pkg;

	localparam logic [6:0] DEV_ADDR   = 7'h38;
	localparam int         NREG       = 45;
	localparam int         IDX_ROUTE  = 0;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	localparam logic [3:0] ACK_BIT    = 4'h8;
	localparam logic [2:0] TX_LAST    = 3'h7;
	localparam logic [1:0] IDX_DATA   = 2'h2;

	localparam logic [7:0] REG_OFFSET [NREG] = '{
		8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19,
		8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25,
		8'h27, 8'h28, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h67,
		8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75, 8'h76, 8'h77, 8'h78, 8'h79,
		8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e};

	localparam logic [7:0] REG_RESET [NREG] = '{
		8'he4, 8'hc0, 8'hc0, 8'h82, 8'h82, 8'h82, 8'hf1, 8'hf3, 8'hf1, 8'hf3,
		8'hf1, 8'hf3, 8'hff, 8'hf8, 8'he0, 8'he0, 8'he0, 8'h44, 8'hf0, 8'hf8,
		8'h00, 8'h00, 8'h35, 8'h33, 8'h6a, 8'h66, 8'ha1, 8'h99, 8'hdc, 8'hcc,
		8'h33, 8'h66, 8'h99, 8'hcc, 8'hff, 8'h33, 8'h66, 8'h99, 8'hcc, 8'hff,
		8'h33, 8'h66, 8'h99, 8'hcc, 8'hff};

	// bits that a write may change; read-only entries hold their power-on value
	localparam logic [7:0] REG_WMASK [NREG] = '{
		8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00,
		8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

	// entry index of each bank's pulse map and brightness, banks a, b, c
	localparam int PULSE_IDX [3] = '{3, 4, 5};
	localparam int LEVEL_IDX [3] = '{6, 8, 10};

	typedef enum logic [1:0] {
		BANK_A = 2'b00,
		BANK_B = 2'b01,
		BANK_C = 2'b10
	} bank_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_RX     = 3'b001,
		ST_ACK    = 3'b010,
		ST_TX     = 3'b011,
		ST_TX_ACK = 3'b100
	} bus_state_t;

	function automatic bank_t bank_of(input logic [1:0] fld);
		if (fld[1]) begin
			return BANK_C;
		end
		return fld[0] ? BANK_B : BANK_A;
	endfunction : bank_of

endpackage : led_bank_routing_pkg

// ===== core/led_bank_routing_regs.sv
// configuration bank with two-wire serial slave and sink-to-bank routing
// assumes scl and sda already synchronous to clk_in and far slower than it
`timescale 1ns/10ps
`default_nettype none
module led_bank_routing_regs (
	input  wire logic                              clk_in,
	input  wire logic                              srst_in,
	input  wire logic                              ce_in,
	input  wire logic                              scl_in,
	input  wire logic                              sda_in,
	output logic                                   sda_out,
	output logic                                   sda_oe_out,
	output led_bank_routing_pkg::bank_t            sink_one_route_out,
	output led_bank_routing_pkg::bank_t            sink_two_route_out,
	output led_bank_routing_pkg::bank_t            sink_three_route_out,
	output logic [7:0]                             sink_one_pulse_map_out,
	output logic [7:0]                             sink_two_pulse_map_out,
	output logic [7:0]                             sink_three_pulse_map_out,
	output logic [7:0]                             sink_one_level_out,
	output logic [7:0]                             sink_two_level_out,
	output logic [7:0]                             sink_three_level_out
);
	import led_bank_routing_pkg::*;

	logic       [7:0] regs [NREG];
	bus_state_t       state_q;
	logic             scl_q;
	logic             sda_q;
	logic       [3:0] bitcnt_q;
	logic       [1:0] byte_idx_q;
	logic       [7:0] rx_sr_q;
	logic       [7:0] tx_sr_q;
	logic       [7:0] ptr_q;
	logic             rw_q;
	logic             nack_q;
	logic             sda_oe_q;
	logic             scl_rise;
	logic             scl_fall;
	logic             start_seen;
	logic             stop_seen;
	logic             byte_done;
	logic             addr_hit;
	logic             wr_en;
	logic       [7:0] rd_data;
	bank_t            route_q [3];
	logic       [7:0] pulse_q [3];
	logic       [7:0] level_q [3];

	assign scl_rise   = scl_in & ~scl_q;
	assign scl_fall   = ~scl_in & scl_q;
	assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
	assign stop_seen  = scl_in & scl_q & ~sda_q & sda_in;
	assign byte_done  = (state_q == ST_RX) && scl_fall && (bitcnt_q == ACK_BIT);
	assign addr_hit   = (rx_sr_q[7:1] == DEV_ADDR);
	assign wr_en      = byte_done && (byte_idx_q == IDX_DATA) && !rw_q;

	// open drain: the pin is only ever pulled low
	assign sda_out    = 1'b0;
	assign sda_oe_out = sda_oe_q;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (ce_in) begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	// register storage with per-entry write mask
	for (genvar i = 0; i < NREG; i++) begin : g_reg
		always_ff @(posedge clk_in) begin
			if (srst_in) begin
				regs[i] <= REG_RESET[i];
			end else if (ce_in && wr_en && (ptr_q == REG_OFFSET[i])) begin
				regs[i] <= (regs[i] & ~REG_WMASK[i]) | (rx_sr_q & REG_WMASK[i]);
			end
		end
	end

	always_comb begin
		rd_data = RD_UNMAPPED;
		for (int i = 0; i < NREG; i++) begin
			if (ptr_q == REG_OFFSET[i]) begin
				rd_data = regs[i];
			end
		end
	end

	// serial slave
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_q    <= ST_IDLE;
			bitcnt_q   <= 4'h0;
			byte_idx_q <= 2'h0;
			rx_sr_q    <= 8'h00;
			tx_sr_q    <= 8'h00;
			ptr_q      <= 8'h00;
			rw_q       <= 1'b0;
			nack_q     <= 1'b1;
			sda_oe_q   <= 1'b0;
		end else if (ce_in) begin
			if (start_seen) begin
				state_q    <= ST_RX;
				bitcnt_q   <= 4'h0;
				byte_idx_q <= 2'h0;
				sda_oe_q   <= 1'b0;
			end else if (stop_seen) begin
				state_q  <= ST_IDLE;
				sda_oe_q <= 1'b0;
			end else begin
				unique case (state_q)
					ST_IDLE: begin
						sda_oe_q <= 1'b0;
					end
					ST_RX: begin
						if (scl_rise) begin
							rx_sr_q  <= {rx_sr_q[6:0], sda_in};
							bitcnt_q <= bitcnt_q + 4'h1;
						end else if (byte_done) begin
							if (byte_idx_q == 2'h0) begin
								if (addr_hit) begin
									rw_q     <= rx_sr_q[0];
									state_q  <= ST_ACK;
									sda_oe_q <= 1'b1;
								end else begin
									state_q <= ST_IDLE;
								end
							end else begin
								if (byte_idx_q == 2'h1) begin
									ptr_q <= rx_sr_q;
								end else begin
									ptr_q <= ptr_q + 8'h01;
								end
								state_q  <= ST_ACK;
								sda_oe_q <= 1'b1;
							end
						end
					end
					ST_ACK: begin
						if (scl_fall) begin
							bitcnt_q <= 4'h0;
							if (byte_idx_q != IDX_DATA) begin
								byte_idx_q <= byte_idx_q + 2'h1;
							end
							if (rw_q && byte_idx_q == 2'h0) begin
								state_q  <= ST_TX;
								tx_sr_q  <= rd_data;
								sda_oe_q <= ~rd_data[7];
								ptr_q    <= ptr_q + 8'h01;
							end else begin
								state_q  <= ST_RX;
								sda_oe_q <= 1'b0;
							end
						end
					end
					ST_TX: begin
						if (scl_fall) begin
							if (bitcnt_q[2:0] == TX_LAST) begin
								state_q  <= ST_TX_ACK;
								sda_oe_q <= 1'b0;
							end else begin
								tx_sr_q  <= {tx_sr_q[6:0], 1'b0};
								sda_oe_q <= ~tx_sr_q[6];
								bitcnt_q <= bitcnt_q + 4'h1;
							end
						end
					end
					ST_TX_ACK: begin
						if (scl_rise) begin
							nack_q <= sda_in;
						end else if (scl_fall) begin
							if (!nack_q) begin
								state_q  <= ST_TX;
								bitcnt_q <= 4'h0;
								tx_sr_q  <= rd_data;
								sda_oe_q <= ~rd_data[7];
								ptr_q    <= ptr_q + 8'h01;
							end else begin
								state_q <= ST_IDLE;
							end
						end
					end
				endcase
			end
		end
	end

	// each sink follows the bank named by its two routing bits
	for (genvar s = 0; s < 3; s++) begin : g_sink
		bank_t fld_bank;
		assign fld_bank = bank_of(regs[IDX_ROUTE][2*s+1 -: 2]);
		always_ff @(posedge clk_in) begin
			if (srst_in) begin
				route_q[s] <= bank_of(REG_RESET[IDX_ROUTE][2*s+1 -: 2]);
				pulse_q[s] <= REG_RESET[PULSE_IDX[0]];
				level_q[s] <= REG_RESET[LEVEL_IDX[0]];
			end else if (ce_in) begin
				route_q[s] <= fld_bank;
				pulse_q[s] <= regs[PULSE_IDX[fld_bank]];
				level_q[s] <= regs[LEVEL_IDX[fld_bank]];
			end
		end
	end

	assign sink_one_route_out       = route_q[0];
	assign sink_two_route_out       = route_q[1];
	assign sink_three_route_out     = route_q[2];
	assign sink_one_pulse_map_out   = pulse_q[0];
	assign sink_two_pulse_map_out   = pulse_q[1];
	assign sink_three_pulse_map_out = pulse_q[2];
	assign sink_one_level_out       = level_q[0];
	assign sink_two_level_out       = level_q[1];
	assign sink_three_level_out     = level_q[2];

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	a_route_one_bank: assert property ($past(ce_in) && !$past(srst_in) |->
		sink_one_pulse_map_out == $past(regs[PULSE_IDX[bank_of(regs[IDX_ROUTE][1:0])]]))
		else $error("sink one pulse map not from its bank");
	a_route_two_bank: assert property ($past(ce_in) && !$past(srst_in) |->
		sink_two_route_out == bank_of($past(regs[IDX_ROUTE][3:2])))
		else $error("sink two route decode wrong");
	a_route_three_bank: assert property ($past(ce_in) && !$past(srst_in) |->
		sink_three_route_out == bank_of($past(regs[IDX_ROUTE][5:4])))
		else $error("sink three route decode wrong");
	a_level_same_bank: assert property ($past(ce_in) && !$past(srst_in) |->
		sink_two_level_out == $past(regs[LEVEL_IDX[bank_of(regs[IDX_ROUTE][3:2])]]))
		else $error("sink two level not from its bank");
	a_addr_match_ack: assert property ($rose(state_q == ST_ACK) && byte_idx_q == 2'h0 |->
		$past(rx_sr_q[7:1]) == 7'h38)
		else $error("acknowledged a foreign address");
	a_reset_values: assert property (disable iff (1'b0) $past(srst_in) |->
		regs[IDX_ROUTE] == 8'he4 && regs[30] == 8'h33 && regs[44] == 8'hff)
		else $error("power-on value not loaded");
	a_ack_drives_low: assert property (state_q == ST_ACK |-> sda_oe_out && !sda_out)
		else $error("ack slot not pulled low");
	a_route_top_ones: assert property (regs[IDX_ROUTE][7:6] == 2'b11)
		else $error("routing top bits not ones");

	a_route_one_decode: assert property ($past(ce_in) && !$past(srst_in) |->
		sink_one_route_out == bank_of($past(regs[IDX_ROUTE][1:0])))
		else $error("sink one route decode wrong");
	a_level_one_bank: assert property ($past(ce_in) && !$past(srst_in) |->
		sink_one_level_out == $past(regs[LEVEL_IDX[bank_of(regs[IDX_ROUTE][1:0])]]))
		else $error("sink one level not from its bank");
	a_pulse_two_bank: assert property ($past(ce_in) && !$past(srst_in) |->
		sink_two_pulse_map_out == $past(regs[PULSE_IDX[bank_of(regs[IDX_ROUTE][3:2])]]))
		else $error("sink two pulse map not from its bank");
	a_pulse_three_bank: assert property ($past(ce_in) && !$past(srst_in) |->
		sink_three_pulse_map_out == $past(regs[PULSE_IDX[bank_of(regs[IDX_ROUTE][5:4])]]))
		else $error("sink three pulse map not from its bank");
	a_level_three_bank: assert property ($past(ce_in) && !$past(srst_in) |->
		sink_three_level_out == $past(regs[LEVEL_IDX[bank_of(regs[IDX_ROUTE][5:4])]]))
		else $error("sink three level not from its bank");

	// bus slave sequencing
	a_ack_after_byte: assert property (ce_in && byte_done && (byte_idx_q != 2'h0 || addr_hit)
		|=> state_q == ST_ACK && sda_oe_out)
		else $error("received byte not acknowledged");
	a_idle_released: assert property (state_q == ST_IDLE |-> !sda_oe_out)
		else $error("data line held while idle");
	a_master_slot_free: assert property (state_q == ST_TX_ACK |-> !sda_oe_out)
		else $error("data line held in master ack slot");
	a_ptr_load: assert property (ce_in && byte_done && byte_idx_q == 2'h1
		|=> ptr_q == $past(rx_sr_q))
		else $error("register address not taken");
	a_nack_ends: assert property (ce_in && state_q == ST_TX_ACK && scl_fall && nack_q
		|=> state_q == ST_IDLE)
		else $error("read not ended by master nack");
	a_tx_first_bit: assert property (ce_in && state_q == ST_ACK && scl_fall && rw_q &&
		byte_idx_q == 2'h0 |=> sda_oe_out == !$past(rd_data[7]))
		else $error("first read bit wrong");
	a_rx_count: assert property (state_q == ST_RX |-> bitcnt_q <= ACK_BIT)
		else $error("receive bit count overran");
	a_freeze_state: assert property (!$past(ce_in) && !$past(srst_in) |->
		$stable(state_q) && $stable(ptr_q) && $stable(regs[IDX_ROUTE]) &&
		$stable(sink_one_route_out))
		else $error("state moved while clock enable low");
	a_ro_hold: assert property (regs[18] == 8'hf0 && regs[19] == 8'hf8 &&
		regs[20] == 8'h00 && regs[21] == 8'h00)
		else $error("read-only entry changed");

	// pointer and data of the last byte taken, so the landing can be checked a cycle later
	logic       wr_seen_q;
	logic [7:0] wr_ptr_q;
	logic [7:0] wr_val_q;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			wr_seen_q <= 1'b0;
			wr_ptr_q  <= 8'h00;
			wr_val_q  <= 8'h00;
		end else if (ce_in) begin
			wr_seen_q <= wr_en;
			wr_ptr_q  <= ptr_q;
			wr_val_q  <= rx_sr_q;
		end
	end

	a_route_write_lands: assert property (wr_seen_q && wr_ptr_q == REG_OFFSET[IDX_ROUTE] |->
		regs[IDX_ROUTE] == {2'b11, wr_val_q[5:0]})
		else $error("routing write did not land");
	a_goal_write_lands: assert property (wr_seen_q && wr_ptr_q == REG_OFFSET[30] |->
		regs[30] == wr_val_q)
		else $error("zone goal write did not land");

	c_write_data: cover property (wr_en && ce_in);
	c_read_byte: cover property (state_q == ST_TX ##1 state_q == ST_TX_ACK);
	c_route_c: cover property (sink_one_route_out == BANK_C);
	c_foreign_addr: cover property (ce_in && byte_done && byte_idx_q == 2'h0 && !addr_hit);
	c_frozen: cover property (!ce_in && scl_fall);

endmodule : led_bank_routing_regs
`default_nettype wire

// ===== test/i2c_host_model.sv
// two-wire bus master model: start, stop, byte transfers, register write and read
// assumes the device pulls data low through sda_oe_in; the data wire has a pull-up
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model (
	input  wire logic clk_in,
	input  wire logic sda_oe_in,
	output var  logic scl_out,
	output wire logic sda_out
);
	logic drv_low;

	// released line floats high through the pull-up
	assign sda_out = ~(drv_low | sda_oe_in);

	initial begin
		drv_low = 1'b0;
		scl_out = 1'b1;
	end

	task automatic q;
		repeat (4) @(posedge clk_in);
		#1;
	endtask : q

	task automatic start;
		drv_low = 1'b0;
		q;
		scl_out = 1'b1;
		q;
		drv_low = 1'b1;
		q;
		scl_out = 1'b0;
		q;
	endtask : start

	task automatic stop;
		drv_low = 1'b1;
		q;
		scl_out = 1'b1;
		q;
		drv_low = 1'b0;
		q;
	endtask : stop

	task automatic bit_x(input logic b, output logic r);
		drv_low = ~b;
		q;
		scl_out = 1'b1;
		q;
		r = sda_out;
		q;
		scl_out = 1'b0;
		q;
	endtask : bit_x

	task automatic byte_x(input logic [7:0] d, input logic nine, output logic [7:0] r,
		output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r[i]);
		end
		bit_x(nine, a);
		ack = ~a;
	endtask : byte_x

	task automatic probe(input logic [7:0] adr, output logic ack);
		logic [7:0] r;
		start;
		byte_x(adr, 1'b1, r, ack);
		stop;
	endtask : probe

	task automatic wr(input logic [7:0] ra, input logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic       a0, a1, a2;
		start;
		byte_x(8'h70, 1'b1, r, a0);
		byte_x(ra, 1'b1, r, a1);
		byte_x(d, 1'b1, r, a2);
		stop;
		ok = a0 & a1 & a2;
	endtask : wr

	task automatic rd(input logic [7:0] ra, output logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic       a0, a1, a2, a3;
		start;
		byte_x(8'h70, 1'b1, r, a0);
		byte_x(ra, 1'b1, r, a1);
		start;
		byte_x(8'h71, 1'b1, r, a2);
		byte_x(8'hff, 1'b1, d, a3);
		stop;
		ok = a0 & a1 & a2;
	endtask : rd
endmodule : i2c_host_model
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the routing register bank
// assumes the bus master model drives the two-wire pins
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import led_bank_routing_pkg::*;
	logic       clk_in, srst_in, scl, sda_wire, oe, ok, ce, sda_pin;
	bank_t      r1, r2, r3;
	logic [7:0] p1, p2, p3, l1, l2, l3;
	logic [7:0] pv [3];
	logic [7:0] lv [3];
	int         n_errors, checks_done;

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	led_bank_routing_regs dut (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce),
		.scl_in(scl), .sda_in(sda_wire), .sda_out(sda_pin), .sda_oe_out(oe),
		.sink_one_route_out(r1), .sink_two_route_out(r2), .sink_three_route_out(r3),
		.sink_one_pulse_map_out(p1), .sink_two_pulse_map_out(p2),
		.sink_three_pulse_map_out(p3), .sink_one_level_out(l1),
		.sink_two_level_out(l2), .sink_three_level_out(l3));
	i2c_host_model host (.clk_in(clk_in), .sda_oe_in(oe), .scl_out(scl), .sda_out(sda_wire));

	task automatic bad(input logic [7:0] got, input logic [7:0] exp);
		n_errors++;
		$display("unexpected at %0t: got %h expected %h", $time, got, exp);
	endtask : bad
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) bad(got, exp);
	endtask : chk8
	task automatic chk1(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) bad({7'h0, got}, {7'h0, exp});
	endtask : chk1
	task automatic chk_route(input bank_t got, input bank_t exp);
		checks_done++;
		if (got !== exp) bad({6'h0, got}, {6'h0, exp});
	endtask : chk_route

	task automatic sinks(input logic [5:0] f);
		bank_t e [3];
		for (int k = 0; k < 3; k++) e[k] = f[2*k+1] ? BANK_C : (f[2*k] ? BANK_B : BANK_A);
		chk_route(r1, e[0]);
		chk_route(r2, e[1]);
		chk_route(r3, e[2]);
		chk8(p1, pv[e[0]]);
		chk8(p2, pv[e[1]]);
		chk8(p3, pv[e[2]]);
		chk8(l1, lv[e[0]]);
		chk8(l2, lv[e[1]]);
		chk8(l3, lv[e[2]]);
	endtask : sinks

	task automatic rd_chk(input logic [7:0] ra, input logic [7:0] exp);
		logic [7:0] d;
		logic       a;
		host.rd(ra, d, a);
		chk1(a, 1'b1);
		chk1(sda_pin, 1'b0);
		chk8(d, exp);
	endtask : rd_chk

	task automatic t_power_on;
		sinks(6'h24);
		for (int i = 0; i < NREG; i++) rd_chk(REG_OFFSET[i], REG_RESET[i]);
	endtask : t_power_on

	task automatic t_routing;
		logic [5:0] f;
		for (int b = 0; b < 3; b++) begin
			pv[b] = 8'(8'h11 * (b + 1));
			lv[b] = 8'(8'h44 + 8'h11 * b);
			host.wr(8'(8'h13 + b), pv[b], ok);
			chk1(ok, 1'b1);
			host.wr(8'(8'h16 + 2 * b), lv[b], ok);
			chk1(ok, 1'b1);
		end
		for (int k = 0; k < 4; k++) begin
			f = {2'(k + 2), 2'(k + 1), 2'(k)};
			host.wr(8'h10, {2'b00, f}, ok);
			repeat (4) @(posedge clk_in);
			sinks(f);
			rd_chk(8'h10, {2'b11, f});
		end
	endtask : t_routing

	task automatic t_refusals;
		host.probe(8'h72, ok);
		chk1(ok, 1'b0);
		host.wr(8'h24, 8'h00, ok);
		chk1(ok, 1'b1);
		rd_chk(8'h24, 8'hf0);
		rd_chk(8'h26, 8'h00);
	endtask : t_refusals

	task automatic t_freeze;
		ce = 1'b0;
		host.wr(8'h10, 8'h00, ok);
		chk1(ok, 1'b0);
		chk_route(r1, BANK_C);
		@(posedge clk_in);
		#1;
		ce = 1'b1;
		rd_chk(8'h10, 8'hd3);
		sinks(6'h13);
	endtask : t_freeze

	task automatic t_mid_reset;
		host.wr(8'h70, 8'h5a, ok);
		@(posedge clk_in);
		#1;
		srst_in = 1'b1;
		repeat (8) @(posedge clk_in);
		#1;
		srst_in = 1'b0;
		for (int b = 0; b < 3; b++) begin
			pv[b] = 8'h82;
			lv[b] = 8'hf1;
		end
		sinks(6'h24);
		rd_chk(8'h10, 8'he4);
		rd_chk(8'h70, 8'h33);
	endtask : t_mid_reset

	task automatic test_done;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : test_done

	initial begin
		#1_000_000;
		n_errors++;
		test_done;
	end

	initial begin
		n_errors = 0;
		checks_done = 0;
		srst_in = 1'b1;
		ce = 1'b1;
		for (int b = 0; b < 3; b++) begin
			pv[b] = 8'h82;
			lv[b] = 8'hf1;
		end
		repeat (8) @(posedge clk_in);
		#1;
		srst_in = 1'b0;
		@(posedge clk_in);
		#1;
		t_power_on;
		t_routing;
		t_freeze;
		t_refusals;
		t_mid_reset;
		test_done;
	end
endmodule : tb_top
`default_nettype wire
